// file: rtl/rsa_pkg.sv
// Shared constants and types for the rotate, subtract and skip datapath.
package rsa_pkg;

  // ---------------------------------------------------------------------------
  // Bus map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WORK = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
  localparam logic [7:0] ADDR_MEM_TOP = 8'h7C;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;

  // ---------------------------------------------------------------------------
  // Command, status and flag word fields
  // ---------------------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 5;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_IMM_LSB = 16;
  localparam int CTRL_USE_IMM = 24;
  localparam int STAT_SKIP = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_DUMMY = 2;
  localparam int FLAGS_W = 6;

  // ---------------------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int SKIP_INSTR_CYCLES = 2;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_ROT_LEFT_MEM = 5'h01,
    OP_ROT_LEFT_ACC = 5'h02,
    OP_ROT_LEFT_CARRY = 5'h03,
    OP_ROT_LEFT_CARRY_WORK = 5'h04,
    OP_ROT_RIGHT_MEM = 5'h05,
    OP_ROT_RIGHT_ACC = 5'h06,
    OP_ROT_RIGHT_CARRY = 5'h07,
    OP_ROT_RIGHT_CARRY_ACC = 5'h08,
    OP_SUB_BORROW = 5'h09,
    OP_SUB_BORROW_MEM = 5'h0A,
    OP_MINUS = 5'h0B,
    OP_MINUS_MEM = 5'h0C,
    OP_DEC_SKIP = 5'h0D,
    OP_DEC_ACC_SKIP = 5'h0E,
    OP_INC_SKIP = 5'h0F,
    OP_INC_ACC_SKIP = 5'h10,
    OP_SET_ALL = 5'h11,
    OP_SET_BIT = 5'h12,
    OP_SKIP_BIT_NZ = 5'h13,
    OP_SKIP_NZ = 5'h14
  } rsa_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b100
  } rsa_state_t;

  // Bit 0 is the signed wrap flag, bit 5 the chained zero flag.
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic carry;
    logic half_carry_flag;
    logic zero;
    logic signed_wrap_flag;
  } rsa_flags_t;

  typedef struct packed {
    logic use_imm;
    logic [7:0] imm;
    logic [MEM_AW-1:0] addr;
    logic [2:0] bit_sel;
    rsa_op_t op;
  } rsa_cmd_t;

endpackage

// file: rtl/rsa_rotator.sv
// One-place byte rotator, plain or through the carry flag.
`timescale 1ns/1ps
module rsa_rotator
(
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic go_right,
  input wire logic thru_carry,
  output logic [7:0] result,
  output logic carry_out
);

  always_comb
  begin
    if (go_right)
    begin
      result = {(thru_carry ? carry_in : operand[0]), operand[7:1]}; // RL3 RL4
      carry_out = thru_carry ? operand[0] : carry_in; // RL4
    end
    else
    begin
      result = {operand[6:0], (thru_carry ? carry_in : operand[7])}; // RL1 RL2
      carry_out = thru_carry ? operand[7] : carry_in; // RL2
    end
  end

endmodule

// file: rtl/rsa_subtractor.sv
// Byte subtractor with optional borrow and full flag set.
`timescale 1ns/1ps
module rsa_subtractor
(
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic use_borrow,
  input wire logic carry_in,
  input wire logic chain_in,
  output logic [7:0] diff,
  output rsa_pkg::rsa_flags_t flags
);

  logic borrow;
  logic [8:0] wide;
  logic [4:0] low;

  always_comb
  begin
    // Carry acts as an inverted borrow, so a clear carry takes one more.
    borrow = use_borrow & ~carry_in; // RL6 RL7
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow};
    diff = wide[7:0];
    flags.carry = ~wide[8]; // RL8
    flags.half_carry_flag = ~low[4]; // RL17
    flags.signed_wrap_flag = (minuend[7] ^ subtrahend[7]) &
                             (minuend[7] ^ wide[7]); // RL17
    flags.zero = (wide[7:0] == rsa_pkg::BYTE_ZERO);
    flags.signed_result_flag = wide[7] ^ flags.signed_wrap_flag; // RL17
    // A chained zero holds only if every stage of a long subtract was zero.
    flags.chained_zero_flag = use_borrow ? (flags.zero & chain_in)
                                         : flags.zero; // RL17
  end

endmodule

// file: rtl/rsa_alu.sv
// Rotate, subtract, set and conditional-skip datapath with an APB slave.
//
// How it works
// RL1 - Rotate left: bit 7 wraps to bit 0
// RL2 - Rotate left through carry, only carry changes
// RL3 - Rotate right: bit 0 wraps to bit 7
// RL4 - Rotate right through carry, only carry changes
// RL5 - Working-register rotates leave memory untouched
// RL6 - Borrow subtract removes operand and inverted carry
// RL7 - Plain subtract uses no borrow input
// RL8 - Subtract carry set when result not negative
// RL9 - Subtracts update all six flags
// RL10 - Decrement memory, skip when zero, flags kept
// RL11 - Increment memory, skip when zero, flags kept
// RL12 - Register forms adjust register, memory unchanged
// RL13 - Skip costs two cycles with dummy slot
// RL14 - Bit test skips when selected bit set
// RL15 - Byte test rewrites byte, skips when nonzero
// RL16 - Set writes all ones or one bit
// RL17 - Other flags use conventional wrap and nibble borrow
`timescale 1ns/1ps
module rsa_alu
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic instr_done,
  output logic dummy_slot,
  output logic skip_taken
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  rsa_pkg::rsa_state_t st_ff, nxt_st;
  rsa_pkg::rsa_cmd_t cmd_ff, nxt_cmd;
  rsa_pkg::rsa_flags_t flags_ff, nxt_flags;
  logic [7:0] work_ff, nxt_work;
  logic [7:0] mem_ff [rsa_pkg::MEM_DEPTH];
  logic [7:0] nxt_mem [rsa_pkg::MEM_DEPTH];
  logic skip_ff, nxt_skip;
  logic done_ff, nxt_done;
  logic dummy_ff, nxt_dummy;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;

  logic [7:0] mem_q;
  logic [7:0] sub_b;
  logic [7:0] rot_res;
  logic rot_c;
  logic [7:0] sub_res;
  rsa_pkg::rsa_flags_t sub_flags;
  logic bus_fire;
  logic is_mem;
  logic [rsa_pkg::MEM_AW-1:0] bus_idx;
  logic busy;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign instr_done = done_ff;
  assign dummy_slot = dummy_ff;
  assign skip_taken = skip_ff;

  assign bus_fire = psel & penable & pready_ff;
  assign is_mem = (paddr >= rsa_pkg::ADDR_MEM_BASE) &&
                  (paddr <= rsa_pkg::ADDR_MEM_TOP) && (paddr[1:0] == 2'h0);
  assign bus_idx = paddr[rsa_pkg::MEM_AW+1:2];
  assign busy = (st_ff != rsa_pkg::ST_IDLE);
  assign mem_q = mem_ff[cmd_ff.addr];
  assign sub_b = cmd_ff.use_imm ? cmd_ff.imm : mem_q; // RL6 RL7

  // ---------------------------------------------------------------------------
  // Arithmetic units
  // ---------------------------------------------------------------------------
  rsa_rotator u_rot
  (
    .operand(mem_q),
    .carry_in(flags_ff.carry),
    .go_right(cmd_ff.op inside {rsa_pkg::OP_ROT_RIGHT_MEM,
                                rsa_pkg::OP_ROT_RIGHT_ACC,
                                rsa_pkg::OP_ROT_RIGHT_CARRY,
                                rsa_pkg::OP_ROT_RIGHT_CARRY_ACC}),
    .thru_carry(cmd_ff.op inside {rsa_pkg::OP_ROT_LEFT_CARRY,
                                  rsa_pkg::OP_ROT_LEFT_CARRY_WORK,
                                  rsa_pkg::OP_ROT_RIGHT_CARRY,
                                  rsa_pkg::OP_ROT_RIGHT_CARRY_ACC}),
    .result(rot_res),
    .carry_out(rot_c)
  );

  rsa_subtractor u_sub
  (
    .minuend(work_ff),
    .subtrahend(sub_b),
    .use_borrow(cmd_ff.op inside {rsa_pkg::OP_SUB_BORROW,
                                  rsa_pkg::OP_SUB_BORROW_MEM}),
    .carry_in(flags_ff.carry),
    .chain_in(flags_ff.chained_zero_flag),
    .diff(sub_res),
    .flags(sub_flags)
  );

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Ready is registered, so with ce high each access phase lasts exactly two cycles.
  always_comb
  begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = rsa_pkg::WORD_ZERO;
    if (psel && penable && !pready_ff)
    begin
      nxt_pready = 1'b1;
      if (pwrite && busy)
        nxt_pslverr = 1'b1;
      else if (is_mem)
        nxt_prdata = {24'h000000, mem_ff[bus_idx]};
      else
      begin
        case (paddr)
          rsa_pkg::ADDR_CTRL:
            nxt_prdata = {7'h00, cmd_ff.use_imm, cmd_ff.imm, 4'h0,
                          cmd_ff.addr, cmd_ff.bit_sel, cmd_ff.op};
          rsa_pkg::ADDR_WORK: nxt_prdata = {24'h000000, work_ff};
          rsa_pkg::ADDR_FLAGS: nxt_prdata = {26'h0000000, flags_ff};
          rsa_pkg::ADDR_STATUS:
            nxt_prdata = {29'h00000000, dummy_ff, busy, skip_ff};
          default: nxt_pslverr = 1'b1;
        endcase
      end
      if (!pwrite && nxt_pslverr)
        nxt_prdata = rsa_pkg::WORD_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= rsa_pkg::WORD_ZERO;
    end
    else if (ce)
    begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Core sequencing and execution
  // ---------------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cmd = cmd_ff;
    nxt_flags = flags_ff;
    nxt_work = work_ff;
    nxt_skip = skip_ff;
    nxt_done = 1'b0;
    nxt_dummy = 1'b0;
    for (int i = 0; i < rsa_pkg::MEM_DEPTH; i++)
      nxt_mem[i] = mem_ff[i];
    case (st_ff)
      rsa_pkg::ST_IDLE:
      begin
        if (bus_fire && pwrite && !pslverr_ff)
        begin
          if (is_mem)
            nxt_mem[bus_idx] = pwdata[7:0];
          else if (paddr == rsa_pkg::ADDR_WORK)
            nxt_work = pwdata[7:0];
          else if (paddr == rsa_pkg::ADDR_FLAGS)
            nxt_flags = pwdata[rsa_pkg::FLAGS_W-1:0];
          else if (paddr == rsa_pkg::ADDR_CTRL)
          begin
            nxt_cmd.op = rsa_pkg::rsa_op_t'(pwdata[rsa_pkg::CTRL_OP_LSB+:5]);
            nxt_cmd.bit_sel = pwdata[rsa_pkg::CTRL_BIT_LSB+:3];
            nxt_cmd.addr = pwdata[rsa_pkg::CTRL_ADDR_LSB+:rsa_pkg::MEM_AW];
            nxt_cmd.imm = pwdata[rsa_pkg::CTRL_IMM_LSB+:8];
            nxt_cmd.use_imm = pwdata[rsa_pkg::CTRL_USE_IMM];
            nxt_skip = 1'b0;
            nxt_st = rsa_pkg::ST_EXEC;
          end
        end
      end
      rsa_pkg::ST_EXEC:
      begin
        nxt_skip = 1'b0;
        case (cmd_ff.op)
          rsa_pkg::OP_ROT_LEFT_MEM, rsa_pkg::OP_ROT_RIGHT_MEM:
            nxt_mem[cmd_ff.addr] = rot_res; // RL1 RL3
          rsa_pkg::OP_ROT_LEFT_ACC, rsa_pkg::OP_ROT_RIGHT_ACC:
            nxt_work = rot_res; // RL5
          rsa_pkg::OP_ROT_LEFT_CARRY, rsa_pkg::OP_ROT_RIGHT_CARRY:
          begin
            nxt_mem[cmd_ff.addr] = rot_res; // RL2 RL4
            nxt_flags.carry = rot_c; // RL2 RL4
          end
          rsa_pkg::OP_ROT_LEFT_CARRY_WORK, rsa_pkg::OP_ROT_RIGHT_CARRY_ACC:
          begin
            nxt_work = rot_res; // RL5
            nxt_flags.carry = rot_c; // RL2 RL4
          end
          rsa_pkg::OP_SUB_BORROW, rsa_pkg::OP_MINUS:
          begin
            nxt_work = sub_res; // RL6 RL7
            nxt_flags = sub_flags; // RL9
          end
          rsa_pkg::OP_SUB_BORROW_MEM, rsa_pkg::OP_MINUS_MEM:
          begin
            nxt_mem[cmd_ff.addr] = sub_res; // RL6 RL7
            nxt_flags = sub_flags; // RL9
          end
          rsa_pkg::OP_DEC_SKIP:
          begin
            nxt_mem[cmd_ff.addr] = mem_q - rsa_pkg::BYTE_ONE; // RL10
            nxt_skip = (mem_q == rsa_pkg::BYTE_ONE); // RL10
          end
          rsa_pkg::OP_INC_SKIP:
          begin
            nxt_mem[cmd_ff.addr] = mem_q + rsa_pkg::BYTE_ONE; // RL11
            nxt_skip = (mem_q == rsa_pkg::BYTE_ALL_ONES); // RL11
          end
          rsa_pkg::OP_DEC_ACC_SKIP:
          begin
            nxt_work = mem_q - rsa_pkg::BYTE_ONE; // RL12
            nxt_skip = (mem_q == rsa_pkg::BYTE_ONE); // RL12
          end
          rsa_pkg::OP_INC_ACC_SKIP:
          begin
            nxt_work = mem_q + rsa_pkg::BYTE_ONE; // RL12
            nxt_skip = (mem_q == rsa_pkg::BYTE_ALL_ONES); // RL12
          end
          rsa_pkg::OP_SET_ALL:
            nxt_mem[cmd_ff.addr] = rsa_pkg::BYTE_ALL_ONES; // RL16
          rsa_pkg::OP_SET_BIT:
            nxt_mem[cmd_ff.addr][cmd_ff.bit_sel] = 1'b1; // RL16
          rsa_pkg::OP_SKIP_BIT_NZ:
            nxt_skip = mem_q[cmd_ff.bit_sel]; // RL14
          rsa_pkg::OP_SKIP_NZ:
          begin
            nxt_mem[cmd_ff.addr] = mem_q; // RL15
            nxt_skip = (mem_q != rsa_pkg::BYTE_ZERO); // RL15
          end
          default: nxt_skip = 1'b0;
        endcase
        // A skip spends a second cycle on the dummy that replaces the
        // discarded instruction.
        if (nxt_skip)
        begin
          nxt_st = rsa_pkg::ST_DUMMY; // RL13
          nxt_dummy = 1'b1; // RL13
        end
        else
        begin
          nxt_st = rsa_pkg::ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      rsa_pkg::ST_DUMMY:
      begin
        nxt_st = rsa_pkg::ST_IDLE; // RL13
        nxt_done = 1'b1;
      end
      default: nxt_st = rsa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= rsa_pkg::ST_IDLE;
      cmd_ff <= '0;
      flags_ff <= '0;
      work_ff <= rsa_pkg::BYTE_ZERO;
      skip_ff <= 1'b0;
      done_ff <= 1'b0;
      dummy_ff <= 1'b0;
      for (int i = 0; i < rsa_pkg::MEM_DEPTH; i++)
        mem_ff[i] <= rsa_pkg::BYTE_ZERO;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
      cmd_ff <= nxt_cmd;
      flags_ff <= nxt_flags;
      work_ff <= nxt_work;
      skip_ff <= nxt_skip;
      done_ff <= nxt_done;
      dummy_ff <= nxt_dummy;
      for (int i = 0; i < rsa_pkg::MEM_DEPTH; i++)
        mem_ff[i] <= nxt_mem[i];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic exec_go;
  assign exec_go = ce && (st_ff == rsa_pkg::ST_EXEC);

  a_rot_left_wrap: assert property ( // RL1
    exec_go && cmd_ff.op == rsa_pkg::OP_ROT_LEFT_MEM |=>
    mem_ff[$past(cmd_ff.addr)] == {$past(mem_q[6:0]), $past(mem_q[7])})
    else $error("rotate left did not wrap bit 7 into bit 0");

  a_rot_left_carry: assert property ( // RL2
    exec_go && cmd_ff.op == rsa_pkg::OP_ROT_LEFT_CARRY |=>
    flags_ff.carry == $past(mem_q[7]) &&
    mem_ff[$past(cmd_ff.addr)][0] == $past(flags_ff.carry))
    else $error("rotate left through carry moved the wrong bits");

  a_rot_right_wrap: assert property ( // RL3
    exec_go && cmd_ff.op == rsa_pkg::OP_ROT_RIGHT_MEM |=>
    mem_ff[$past(cmd_ff.addr)] == {$past(mem_q[0]), $past(mem_q[7:1])} &&
    $stable(flags_ff))
    else $error("rotate right did not wrap bit 0 into bit 7");

  a_work_rot_mem: assert property ( // RL5
    exec_go && cmd_ff.op == rsa_pkg::OP_ROT_RIGHT_CARRY_ACC |=>
    work_ff == {$past(flags_ff.carry), $past(mem_q[7:1])} &&
    mem_ff[$past(cmd_ff.addr)] == $past(mem_q))
    else $error("register rotate disturbed memory or missed register");

  a_sub_carry: assert property ( // RL8
    exec_go && cmd_ff.op == rsa_pkg::OP_MINUS |=>
    flags_ff.carry == ($past(work_ff) >= $past(sub_b)))
    else $error("subtract carry does not match sign of result");

  a_dec_skip: assert property ( // RL10
    exec_go && cmd_ff.op == rsa_pkg::OP_DEC_SKIP |=>
    skip_ff == ($past(mem_q) == 8'h01) && $stable(flags_ff))
    else $error("decrement skip decision or flags wrong");

  a_skip_two: assert property ( // RL13
    exec_go && nxt_skip ##1 ce |-> dummy_ff ##1 done_ff && !busy)
    else $error("skip did not take exactly two cycles");

  a_bit_skip: assert property ( // RL14
    exec_go && cmd_ff.op == rsa_pkg::OP_SKIP_BIT_NZ |=>
    skip_ff == $past(mem_q[cmd_ff.bit_sel]))
    else $error("bit test skip decision wrong");

  a_set_all: assert property ( // RL16
    exec_go && cmd_ff.op == rsa_pkg::OP_SET_ALL |=>
    mem_ff[$past(cmd_ff.addr)] == 8'hFF && $stable(flags_ff))
    else $error("set did not write all ones");

  c_skip_taken: cover property (exec_go && nxt_skip ##1 dummy_ff);
  c_sub_borrow: cover property (exec_go &&
    cmd_ff.op == rsa_pkg::OP_SUB_BORROW && !flags_ff.carry);
  c_busy_write: cover property (bus_fire && pwrite && pslverr_ff && busy);

endmodule

// file: bench/tb.sv
// Self-checking bench for the rotate, subtract and skip datapath.
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, instr_done, dummy_slot, skip_taken;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err, saw_dummy, c, thru, right, tomem, bw, ui;
  logic [8:0] full;
  logic [4:0] hb;
  logic [7:0] x, a, b, r, res;
  logic [5:0] fl;
  logic [32:0] ent;
  logic [7:0] sa [4] = '{8'h50, 8'h30, 8'h20, 8'h80};
  logic [7:0] sb [4] = '{8'h30, 8'h50, 8'h1F, 8'h01};
  logic [3:0] scin = 4'b0011;
  // Each entry: op, bit, memory in, memory out, work out, skip.
  logic [32:0] sk_tab [15] = '{
    {5'h0D, 3'd0, 8'h01, 8'h00, 8'h33, 1'b1},
    {5'h0D, 3'd0, 8'h00, 8'hFF, 8'h33, 1'b0},
    {5'h0E, 3'd0, 8'h01, 8'h01, 8'h00, 1'b1},
    {5'h0E, 3'd0, 8'h05, 8'h05, 8'h04, 1'b0},
    {5'h0F, 3'd0, 8'hFF, 8'h00, 8'h33, 1'b1},
    {5'h0F, 3'd0, 8'h7F, 8'h80, 8'h33, 1'b0},
    {5'h10, 3'd0, 8'hFF, 8'hFF, 8'h00, 1'b1},
    {5'h10, 3'd0, 8'h00, 8'h00, 8'h01, 1'b0},
    {5'h13, 3'd3, 8'h08, 8'h08, 8'h33, 1'b1},
    {5'h13, 3'd3, 8'hF7, 8'hF7, 8'h33, 1'b0},
    {5'h14, 3'd0, 8'h40, 8'h40, 8'h33, 1'b1},
    {5'h14, 3'd0, 8'h00, 8'h00, 8'h33, 1'b0},
    {5'h11, 3'd0, 8'h12, 8'hFF, 8'h33, 1'b0},
    {5'h12, 3'd5, 8'h12, 8'h32, 8'h33, 1'b0},
    {5'h12, 3'd7, 8'h00, 8'h80, 8'h33, 1'b0}};

  always #20 pclk = ~pclk;

  rsa_alu i_rsa_alu (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_done(instr_done), .dummy_slot(dummy_slot),
    .skip_taken(skip_taken));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind it so
  // that the next setup never lands in the step that releases psel.
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      fail_count++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    apb(1'b0, ad, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
  endtask

  function automatic logic [7:0] maddr(input int m);
    return rsa_pkg::ADDR_MEM_BASE + 8'(4 * m);
  endfunction

  task automatic prep(input logic [7:0] w, input logic [7:0] m,
                      input logic [5:0] f);
    apb(1'b1, rsa_pkg::ADDR_WORK, {24'h00_0000, w});
    apb(1'b1, maddr(2), {24'h00_0000, m});
    apb(1'b1, rsa_pkg::ADDR_FLAGS, {26'h000_0000, f});
  endtask

  // A plain instruction ends one cycle after the idle cycle, a skip two.
  task automatic run(input logic [4:0] op, input logic [2:0] bs,
                     input logic [7:0] imm, input logic ui, input logic sk);
    int n;
    apb(1'b1, rsa_pkg::ADDR_CTRL, {7'h00, ui, imm, 8'h02, bs, op});
    saw_dummy = 1'b0;
    for (n = 1; n < 20; n++)
    begin
      @(posedge pclk);
      saw_dummy = saw_dummy | dummy_slot;
      if (instr_done === 1'b1)
        break;
    end
    if (n == 20)
    begin
      fail_count++;
      complete_run();
    end
    chk(32'(n), sk ? 32'd2 : 32'd1);
    chk({31'h0, saw_dummy}, {31'h0, sk});
    chk({31'h0, skip_taken}, {31'h0, sk});
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(rsa_pkg::ADDR_WORK, 8'h00);
    rchk(rsa_pkg::ADDR_FLAGS, 8'h00);
    rchk(maddr(2), 8'h00);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset and map done");
    x = 8'h96;
    for (int ci = 0; ci < 2; ci++)
      for (int op = 1; op <= 8; op++)
      begin
        c = ci[0];
        thru = (op == 3) || (op == 4) || (op == 7) || (op == 8);
        right = op >= 5;
        tomem = (op == 1) || (op == 3) || (op == 5) || (op == 7);
        res = right ? {thru ? c : x[0], x[7:1]} : {x[6:0], thru ? c : x[7]};
        fl = {2'b10, thru ? (right ? x[0] : x[7]) : c, 3'b000};
        prep(8'h5A, x, {2'b10, c, 3'b000});
        run(5'(op), 3'd0, 8'h00, 1'b0, 1'b0);
        rchk(maddr(2), tomem ? res : x);
        rchk(rsa_pkg::ADDR_WORK, tomem ? 8'h5A : res);
        rchk(rsa_pkg::ADDR_FLAGS, {2'b00, fl});
      end
    $display("test rotate done");
    for (int op = 9; op <= 12; op++)
      for (int k = 0; k < 4; k++)
      begin
        a = sa[k];
        b = sb[k];
        c = scin[k];
        tomem = (op == 10) || (op == 12);
        ui = k[0] & ~tomem;
        bw = (op <= 10) ? ~c : 1'b0;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bw};
        hb = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
        r = full[7:0];
        fl[0] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
        fl[1] = r == 8'h00;
        fl[2] = ~hb[4];
        fl[3] = ~full[8];
        fl[4] = r[7] ^ fl[0];
        fl[5] = fl[1];
        prep(a, ui ? 8'hEE : b, {2'b10, c, 3'b000});
        run(5'(op), 3'd0, b, ui, 1'b0);
        apb(1'b0, rsa_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(rd, {7'h00, ui, b, 8'h02, 3'h0, 5'(op)});
        rchk(rsa_pkg::ADDR_WORK, tomem ? a : r);
        rchk(maddr(2), tomem ? r : (ui ? 8'hEE : b));
        rchk(rsa_pkg::ADDR_FLAGS, {2'b00, fl});
      end
    $display("test subtract done");
    for (int k = 0; k < 15; k++)
    begin
      ent = sk_tab[k];
      prep(8'h33, ent[24:17], 6'h15);
      run(ent[32:28], ent[27:25], 8'h00, 1'b0, ent[0]);
      rchk(maddr(2), ent[16:9]);
      rchk(rsa_pkg::ADDR_WORK, ent[8:1]);
      rchk(rsa_pkg::ADDR_STATUS, {7'h00, ent[0]});
      rchk(rsa_pkg::ADDR_FLAGS, 8'h15);
    end
    $display("test skip and set done");
    complete_run();
  end
endmodule
